// file: rtl/adcdc_readout.sv
// serial readout of a converter result in daisy-chain operation
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - with chain input and conversion start both low the serial output is driven low, except while converting with the indicator off, when it is released.
// - a conversion start rising edge while the shift clock is high starts a conversion.
// - such a start selects chain operation with the completion indicator enabled.
// - with the indicator on, the output goes high once the whole chain has converted.
// - after conversion the converter acquires and idles in standby until the next start.
// - the result leaves msb first, one bit per later falling shift clock edge.
// - each falling shift clock edge in readback loads the chain input into the register's input end, except the first one with the indicator on.
// - a start edge while the shift clock is low selects chain mode, indicator off.
// - with the indicator off the msb appears as soon as the conversion completes.
// - the output stays valid across both shift clock edges after its update.
////////////////////////////////////////////////////////////////////////////////
// the pins are sampled by the block clock, so every shift clock phase must last
// several block clock periods; a level seen on fewer than two edges is dropped
// a conversion completes only once a sample word waits in the buffer, so with no
// word offered the block stays busy instead of shifting out a stale result
module adcdc_readout #(
  parameter int RESULT_W = adcdc_pkg::RESULT_W,
  parameter int CONV_CYCLES = adcdc_pkg::CONV_CYCLES
) (
  input wire logic ref_clk_in,                    // 20 MHz block clock
  input wire logic srst_in,                       // synchronous reset, high
  input wire logic conversion_start_in,           // conversion start pin
  input wire logic shift_clk_in,                  // link shift clock pin
  input wire logic serial_chain_in,               // upstream chain data pin
  input wire logic [RESULT_W-1:0] sample_data_in, // converted sample word
  input wire logic sample_valid_in,               // sample word offered
  output logic sample_ready_out,                  // buffer can take a word
  output logic serial_result_out,                 // serial output level
  output logic serial_result_oe_out,              // serial output drive enable
  output logic busy_ind_en_out,                   // indicator mode selected
  output logic converting_out                     // conversion in progress
);
  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers; changes count once stages two and three agree
  // reset clears every stage, so the pins read low until real levels pass through
  logic [adcdc_pkg::SYNC_STAGES-1:0] cnv_s_r, sck_s_r, sdi_s_r;
  logic cnv_r, sck_r, sdi_r;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cnv_s_r <= '0;
      sck_s_r <= '0;
      sdi_s_r <= '0;
    end else begin
      cnv_s_r <= {cnv_s_r[1:0], conversion_start_in};
      sck_s_r <= {sck_s_r[1:0], shift_clk_in};
      sdi_s_r <= {sdi_s_r[1:0], serial_chain_in};
    end
  end

  // filtered levels only move when the last two stages agree
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cnv_r <= 1'b0;
      sck_r <= 1'b0;
      sdi_r <= 1'b0;
    end else begin
      if (cnv_s_r[1] == cnv_s_r[2]) cnv_r <= cnv_s_r[2];
      if (sck_s_r[1] == sck_s_r[2]) sck_r <= sck_s_r[2];
      if (sdi_s_r[1] == sdi_s_r[2]) sdi_r <= sdi_s_r[2];
    end
  end

  // previous filtered levels; both reset to the filtered reset level so that
  // no false start or shift edge is seen in the first cycle after reset
  logic cnv_d_r, sck_d_r;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cnv_d_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      cnv_d_r <= cnv_r;
      sck_d_r <= sck_r;
    end
  end
  // one-cycle edge strobes on the filtered levels
  logic cnv_rise, sck_fall;
  assign cnv_rise = cnv_r & ~cnv_d_r;
  assign sck_fall = ~sck_r & sck_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer for sample words; a late consumer never drops a word
  logic [RESULT_W-1:0] buf_mem_r [adcdc_pkg::BUF_DEPTH];
  logic buf_wp_r, buf_rp_r;
  logic [1:0] buf_cnt_r;
  logic buf_push, buf_pop, buf_out_valid;
  // a word is pushed when offered and ready; the sequencer pops it at completion
  assign buf_out_valid = (buf_cnt_r != 2'd0);
  assign buf_push = sample_valid_in & sample_ready_out;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      buf_cnt_r <= 2'd0;
      sample_ready_out <= 1'b1;
    end else begin
      if (buf_push) begin
        buf_mem_r[buf_wp_r] <= sample_data_in;
        buf_wp_r <= ~buf_wp_r;
      end
      if (buf_pop) buf_rp_r <= ~buf_rp_r;
      buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
      // ready is taken from the next count, so it stays a flop and still loses no slot
      sample_ready_out <= (buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop}) <
                          2'(adcdc_pkg::BUF_DEPTH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer: idle waits for a start edge, conv counts the conversion
  // time, read holds the result for shifting until the host drops conversion start
  adcdc_pkg::adcdc_state_t state_r;
  logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt_r;
  logic [RESULT_W-1:0] shreg_r;
  logic done_pulse;
  assign done_pulse = (state_r == adcdc_pkg::ADCDC_CONV) && (conv_cnt_r == '0) &&
                      buf_out_valid;
  assign buf_pop = done_pulse;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_r <= adcdc_pkg::ADCDC_IDLE;
      conv_cnt_r <= '0;
      busy_ind_en_out <= 1'b0;
      converting_out <= 1'b0;
    end else begin
      case (state_r)
        adcdc_pkg::ADCDC_IDLE: begin
          if (cnv_rise) begin
            state_r <= adcdc_pkg::ADCDC_CONV;
            busy_ind_en_out <= sck_r;
            conv_cnt_r <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
            converting_out <= 1'b1;
          end
        end
        adcdc_pkg::ADCDC_READ: begin
          // dropping conversion start ends the readback and returns to standby
          if (!cnv_r) begin
            state_r <= adcdc_pkg::ADCDC_IDLE;
          end
        end
        adcdc_pkg::ADCDC_CONV: begin
          // a missing sample word holds the conversion open instead of showing stale data
          if (conv_cnt_r != '0) begin
            conv_cnt_r <= conv_cnt_r - 1'b1;
          end else if (buf_out_valid) begin
            // acquisition then standby until the next start edge
            state_r <= adcdc_pkg::ADCDC_READ;
            converting_out <= 1'b0;
          end
        end
        default: state_r <= adcdc_pkg::ADCDC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register: load on completion, shift chain input in on falling edges
  logic ind_pending_r;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      shreg_r <= '0;
      ind_pending_r <= 1'b0;
    end else if (done_pulse) begin
      shreg_r <= buf_mem_r[buf_rp_r];
      ind_pending_r <= busy_ind_en_out;
    end else if (state_r == adcdc_pkg::ADCDC_READ && sck_fall) begin
      if (ind_pending_r) begin
        // first falling edge with indicator on only clears the busy-high bit
        ind_pending_r <= 1'b0;
      end else begin
        shreg_r <= {shreg_r[RESULT_W-2:0], sdi_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle level rule of the pin: driven low only while chain input and start are both low;
  // shared by standby and by the end of readback so both keep the same rule
  function automatic logic idle_drive(input logic chain_lvl, input logic start_lvl);
    return ~chain_lvl & ~start_lvl;
  endfunction

  // output drive; shifted result bits change only after falling edges so each holds across both edges
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      serial_result_out <= 1'b0;
      serial_result_oe_out <= 1'b0;
    end else begin
      case (state_r)
        adcdc_pkg::ADCDC_CONV: begin
          if (busy_ind_en_out) begin
            // high only once upstream has also finished (its output high)
            serial_result_out <= 1'b0;
            serial_result_oe_out <= 1'b1;
          end else begin
            serial_result_out <= 1'b0;
            serial_result_oe_out <= 1'b0;
          end
        end
        adcdc_pkg::ADCDC_READ: begin
          if (!cnv_r) begin
            // start already low: readback is over, so the idle rule applies at once
            serial_result_oe_out <= idle_drive(sdi_r, cnv_r);
            serial_result_out <= 1'b0;
          end else begin
            serial_result_oe_out <= 1'b1;
            if (ind_pending_r) serial_result_out <= sdi_r;
            else serial_result_out <= shreg_r[RESULT_W-1];
          end
        end
        default: begin
          serial_result_oe_out <= idle_drive(sdi_r, cnv_r);
          serial_result_out <= 1'b0;
        end
      endcase
    end
  end
endmodule

// file: rtl/adcdc_pkg.sv
// shared constants for the daisy-chain converter readout block
package adcdc_pkg;
  localparam int RESULT_W = 16;         // result width in bits
  localparam int SYNC_STAGES = 3;       // pin synchroniser depth
  localparam int CONV_TIME_NS = 700;    // conversion time, free figure
  localparam int CLK_PERIOD_NS = 50;    // ref clock period
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUF_DEPTH = 2;         // result hand-off buffer entries
  typedef enum logic [1:0] {ADCDC_IDLE, ADCDC_CONV, ADCDC_READ} adcdc_state_t;
endpackage

// file: testbench/adcdc_host_model.sv
// host model driving conversion start, shift clock and chain data
`timescale 1ns/100ps
module adcdc_host_model (
  input wire logic clk_in, // block clock
  input wire logic result_in, // serial result
  output logic start_out = 1'b0, // conversion start
  output logic sck_out = 1'b0, // shift clock
  output logic chain_out = 1'b0 // chain data
);
  // the shift clock level at the start edge picks the mode
  task automatic convert(input logic ind);
    chain_out = 1'b1;
    sck_out = ind;
    repeat (8) @(negedge clk_in);
    start_out = 1'b1;
  endtask
  // sample late in the high phase, since the output moves a few clocks after a fall
  task automatic read(input int n, output logic [17:0] bits);
    bits = '0;
    sck_out = 1'b1;
    repeat (4) @(negedge clk_in);
    for (int i = 0; i < n; i++) begin
      bits = {bits[16:0], result_in};
      sck_out = 1'b0;
      repeat (4) @(negedge clk_in);
      sck_out = 1'b1;
      repeat (4) @(negedge clk_in);
    end
  endtask
  // the next start waits for this, after the whole readback
  task automatic finish(input logic ch);
    start_out = 1'b0;
    chain_out = ch;
    repeat (8) @(negedge clk_in);
  endtask
endmodule

// file: testbench/adcdc_readout_monitor.sv
// port assertions for the chain readout block
`timescale 1ns/100ps
module adcdc_readout_monitor #(
  parameter int RESULT_W = 16,
  parameter int CONV_CYCLES = 14
) (
  input wire logic ref_clk_in, // block clock
  input wire logic srst_in, // synchronous reset
  input wire logic conversion_start_in, // start pin
  input wire logic shift_clk_in, // shift clock pin
  input wire logic serial_chain_in, // chain data pin
  input wire logic [RESULT_W-1:0] sample_data_in, // sample word
  input wire logic sample_valid_in, // word offered
  input wire logic sample_ready_out, // buffer ready
  input wire logic serial_result_out, // serial output level
  input wire logic serial_result_oe_out, // serial output enable
  input wire logic busy_ind_en_out, // indicator mode
  input wire logic converting_out // conversion running
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  // pin levels are held six edges so the synchroniser has caught up
  AST_IDLE_LOW: assert property ((!conversion_start_in && !serial_chain_in)[*6] |->
    serial_result_oe_out && !serial_result_out) else $error("idle not low");
  AST_RELEASE: assert property ((!conversion_start_in && serial_chain_in)[*6] |->
    !serial_result_oe_out) else $error("idle driven");
  AST_START: assert property ($rose(conversion_start_in) && !converting_out |->
    ##[2:8] converting_out) else $error("start lost");
  AST_LEN: assert property ($rose(converting_out) |->
    converting_out[*8] ##1 converting_out[*6]) else $error("conversion short");
  AST_MODE: assert property ($rose(converting_out) && shift_clk_in == $past(shift_clk_in, 8)
    |=> busy_ind_en_out == $past(shift_clk_in)) else $error("wrong mode");
  AST_BUSY: assert property ($fell(converting_out) && busy_ind_en_out && serial_chain_in |->
    ##[0:3] serial_result_oe_out && serial_result_out) else $error("no busy flag");
  AST_MSB: assert property ($fell(converting_out) && !busy_ind_en_out |->
    ##[0:3] serial_result_oe_out) else $error("msb not shown");
  AST_HOLD: assert property (conversion_start_in && $past(conversion_start_in, 6) &&
    serial_result_oe_out && !converting_out |=> serial_result_oe_out) else $error("output dropped");
  cover property ($rose(converting_out) ##1 busy_ind_en_out);
  cover property ($rose(converting_out) ##1 !busy_ind_en_out);
  cover property (!sample_ready_out);
endmodule
bind adcdc_readout adcdc_readout_monitor #(.RESULT_W(RESULT_W), .CONV_CYCLES(CONV_CYCLES)) mon (
  .ref_clk_in, .srst_in, .conversion_start_in, .shift_clk_in, .serial_chain_in,
  .sample_data_in, .sample_valid_in, .sample_ready_out, .serial_result_out,
  .serial_result_oe_out, .busy_ind_en_out, .converting_out);

// file: testbench/adcdc_readout_bench.sv
// self-checking bench for the chain readout block
`timescale 1ns/100ps
module adcdc_readout_bench;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic sample_valid_in = 1'b0;
  logic [15:0] sample_data_in = 16'h0000;
  logic conversion_start_in, shift_clk_in, serial_chain_in, sample_ready_out;
  logic serial_result_out, serial_result_oe_out, busy_ind_en_out, converting_out;
  int mismatches = 0;
  int checked = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  adcdc_readout #(.CONV_CYCLES(14)) dut (.ref_clk_in, .srst_in, .conversion_start_in,
    .shift_clk_in, .serial_chain_in, .sample_data_in, .sample_valid_in, .sample_ready_out,
    .serial_result_out, .serial_result_oe_out, .busy_ind_en_out, .converting_out);
  adcdc_host_model host (.clk_in(ref_clk_in), .result_in(serial_result_out),
    .start_out(conversion_start_in), .sck_out(shift_clk_in), .chain_out(serial_chain_in));
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // two words back to back fill the buffer until it refuses
  task automatic fill_buffer();
    for (int i = 0; i < 2; i++) begin
      @(negedge ref_clk_in);
      sample_data_in = i ? 16'h1E0F : 16'hA5C3;
      sample_valid_in = 1'b1;
    end
    @(negedge ref_clk_in);
    sample_valid_in = 1'b0;
    @(negedge ref_clk_in);
    check(sample_ready_out, 1'b0); // full buffer refuses
  endtask
  // one conversion and readback; chain input high so one extra bit follows the word
  task automatic readout(input logic m, input logic [15:0] w, input int n);
    logic [17:0] bits;
    host.convert(m);
    for (int k = 0; k < 200 && !(converting_out === 1'b0 && serial_result_oe_out === 1'b1
      && (!m || serial_result_out === 1'b1)); k++) @(negedge ref_clk_in);
    // a wait that ran out shows here as a mismatch, never as a silent skip
    check({converting_out, serial_result_oe_out, serial_result_out},
      {2'b01, m | w[15]});
    check(busy_ind_en_out, m);
    host.read(n, bits);
    check(bits, {m, w, 1'b1});
    host.finish(1'b1);
    check(serial_result_oe_out, 1'b0);
    host.finish(1'b0);
    check({serial_result_oe_out, serial_result_out}, 2'b10);
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_in);
    srst_in = 1'b0;
    fill_buffer();
    readout(1'b0, 16'hA5C3, 17);
    readout(1'b1, 16'h1E0F, 18);
    print_verdict();
  end
  // a hang ends the run as a failure
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule
